// ### hw/cds_if.sv
`timescale 1ns/1ns
interface cds_if;
    logic m_scl_o;
    logic m_scl_oe_n;
    logic m_sda_o;
    logic m_sda_oe_n;
    logic s_sda_o;
    logic s_sda_oe_n;
    logic scl;
    logic sda;

    // Open-drain wires with pull-ups
    assign scl = m_scl_oe_n | m_scl_o;
    assign sda = (m_sda_oe_n | m_sda_o) & (s_sda_oe_n | s_sda_o);

    modport master (input sda, output m_scl_o, output m_scl_oe_n,
                    output m_sda_o, output m_sda_oe_n);
    modport slave  (input scl, input sda, output s_sda_o, output s_sda_oe_n);
endinterface : cds_if

// ### hw/cds_master.sv
`timescale 1ns/1ns
module cds_master #(
    parameter int QTR_CYC = cds_pkg::CDS_QTR_CYC
) (
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    cds_if.master                  bus,
    input  wire logic              cmd_valid,
    output logic                   cmd_ready,
    input  wire logic              cmd_read,
    input  wire logic [6:0]        cmd_dev_addr,
    input  wire cds_pkg::cds_byte_t cmd_mem_addr,
    input  wire cds_pkg::cds_byte_t cmd_wdata,
    output logic                   rsp_valid,
    output cds_pkg::cds_byte_t     rsp_rdata,
    output logic                   rsp_nack
);
    import cds_pkg::*;

    cds_mst_state_e st_reg;
    cds_mst_state_e st_next;
    logic [15:0]    div_reg;
    logic [15:0]    div_next;
    logic [1:0]     q_reg;
    logic [1:0]     q_next;
    logic [3:0]     bit_reg;
    logic [3:0]     bit_next;
    logic [1:0]     byte_reg;
    logic [1:0]     byte_next;
    logic           rd_reg;
    logic           rd_next;
    cds_byte_t      tx_reg;
    cds_byte_t      tx_next;
    cds_byte_t      mem_reg;
    cds_byte_t      mem_next;
    cds_byte_t      wd_reg;
    cds_byte_t      wd_next;
    cds_byte_t      rx_reg;
    cds_byte_t      rx_next;
    logic           nack_reg;
    logic           nack_next;
    logic           scl_oe_n_reg;
    logic           scl_oe_n_next;
    logic           sda_oe_n_reg;
    logic           sda_oe_n_next;
    logic           rsp_v_reg;
    logic           rsp_v_next;
    cds_byte_t      rsp_d_reg;
    cds_byte_t      rsp_d_next;
    logic           rsp_n_reg;
    logic           rsp_n_next;
    logic [2:0]     sda_sync_reg;
    logic           sda_f_reg;
    logic           sda_f_next;
    logic           tick;
    logic           rx_byte;
    logic [1:0]     last_byte;

    assign tick      = div_reg == '0;
    assign rx_byte   = rd_reg & (byte_reg == CDS_IDX_MEM);
    assign last_byte = rd_reg ? CDS_IDX_MEM : CDS_IDX_DATA;
    assign sda_f_next = (sda_sync_reg[1] == sda_sync_reg[2]) ? sda_sync_reg[2]
                                                            : sda_f_reg;

    always_comb
    begin
        st_next       = st_reg;
        div_next      = tick ? 16'(QTR_CYC - 1) : div_reg - 16'h0001;
        q_next        = q_reg;
        bit_next      = bit_reg;
        byte_next     = byte_reg;
        rd_next       = rd_reg;
        tx_next       = tx_reg;
        mem_next      = mem_reg;
        wd_next       = wd_reg;
        rx_next       = rx_reg;
        nack_next     = nack_reg;
        scl_oe_n_next = scl_oe_n_reg;
        sda_oe_n_next = sda_oe_n_reg;
        rsp_v_next    = 1'h0;
        rsp_d_next    = rsp_d_reg;
        rsp_n_next    = rsp_n_reg;
        if (st_reg == CDS_M_IDLE)
        begin
            if (cmd_valid)
            begin
                st_next   = CDS_M_START;
                div_next  = 16'(QTR_CYC - 1);
                q_next    = '0;
                rd_next   = cmd_read;
                tx_next   = {cmd_dev_addr, cmd_read};
                mem_next  = cmd_mem_addr;
                wd_next   = cmd_wdata;
                nack_next = 1'h0;
            end
        end
        else if (tick)
        begin
            q_next = q_reg + 2'h1;
            unique case (st_reg)
                CDS_M_START:
                begin
                    if (q_reg == 2'h1)
                    begin
                        sda_oe_n_next = 1'h0;
                    end
                    if (q_reg == 2'h3)
                    begin
                        scl_oe_n_next = 1'h0;
                        st_next       = CDS_M_BIT;
                        bit_next      = '0;
                        byte_next     = CDS_IDX_ADDR;
                    end
                end
                CDS_M_BIT:
                begin
                    unique case (q_reg)
                        2'h0:
                        begin
                            // Read data and the final NACK leave SDA released
                            sda_oe_n_next = rx_byte | (bit_reg == CDS_BIT_ACK)
                                          | tx_reg[7];
                        end
                        2'h1:
                        begin
                            scl_oe_n_next = 1'h1;
                        end
                        2'h2:
                        begin
                            if (rx_byte && bit_reg != CDS_BIT_ACK)
                            begin
                                rx_next = {rx_reg[6:0], sda_f_reg};
                            end
                            if (!rx_byte && bit_reg == CDS_BIT_ACK)
                            begin
                                nack_next = sda_f_reg;
                            end
                        end
                        2'h3:
                        begin
                            scl_oe_n_next = 1'h0;
                            if (bit_reg == CDS_BIT_ACK)
                            begin
                                bit_next = '0;
                                if (nack_reg || byte_reg == last_byte)
                                begin
                                    st_next = CDS_M_STOP;
                                end
                                else
                                begin
                                    byte_next = byte_reg + 2'h1;
                                    tx_next   = (byte_reg == CDS_IDX_ADDR) ? mem_reg
                                                                           : wd_reg;
                                end
                            end
                            else
                            begin
                                bit_next = bit_reg + 4'h1;
                                tx_next  = {tx_reg[6:0], 1'h1};
                            end
                        end
                    endcase
                end
                CDS_M_STOP:
                begin
                    unique case (q_reg)
                        2'h0: sda_oe_n_next = 1'h0;
                        2'h1: scl_oe_n_next = 1'h1;
                        2'h2: sda_oe_n_next = 1'h1;
                        2'h3:
                        begin
                            st_next    = CDS_M_IDLE;
                            rsp_v_next = 1'h1;
                            rsp_d_next = rx_reg;
                            rsp_n_next = nack_reg;
                        end
                    endcase
                end
                default:
                begin
                    st_next = CDS_M_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_reg       <= CDS_M_IDLE;
            div_reg      <= '0;
            q_reg        <= '0;
            bit_reg      <= '0;
            byte_reg     <= CDS_IDX_ADDR;
            rd_reg       <= 1'h0;
            tx_reg       <= CDS_CH_RST;
            mem_reg      <= CDS_CH_RST;
            wd_reg       <= CDS_CH_RST;
            rx_reg       <= CDS_CH_RST;
            nack_reg     <= 1'h0;
            scl_oe_n_reg <= 1'h1;
            sda_oe_n_reg <= 1'h1;
            rsp_v_reg    <= 1'h0;
            rsp_d_reg    <= CDS_CH_RST;
            rsp_n_reg    <= 1'h0;
            sda_sync_reg <= 3'h7;
            sda_f_reg    <= 1'h1;
        end
        else
        begin
            st_reg       <= st_next;
            div_reg      <= div_next;
            q_reg        <= q_next;
            bit_reg      <= bit_next;
            byte_reg     <= byte_next;
            rd_reg       <= rd_next;
            tx_reg       <= tx_next;
            mem_reg      <= mem_next;
            wd_reg       <= wd_next;
            rx_reg       <= rx_next;
            nack_reg     <= nack_next;
            scl_oe_n_reg <= scl_oe_n_next;
            sda_oe_n_reg <= sda_oe_n_next;
            rsp_v_reg    <= rsp_v_next;
            rsp_d_reg    <= rsp_d_next;
            rsp_n_reg    <= rsp_n_next;
            sda_sync_reg <= {sda_sync_reg[1:0], bus.sda};
            sda_f_reg    <= sda_f_next;
        end
    end

    assign cmd_ready      = st_reg == CDS_M_IDLE;
    assign rsp_valid      = rsp_v_reg;
    assign rsp_rdata      = rsp_d_reg;
    assign rsp_nack       = rsp_n_reg;
    assign bus.m_scl_o    = 1'h0;
    assign bus.m_scl_oe_n = scl_oe_n_reg;
    assign bus.m_sda_o    = 1'h0;
    assign bus.m_sda_oe_n = sda_oe_n_reg;
endmodule : cds_master

// ### hw/cds_pkg.sv
package cds_pkg;
    localparam int         CDS_CLK_NS        = 100;
    localparam int         CDS_SCL_PERIOD_NS = 2000;
    localparam int         CDS_QTR_CYC       =
        (CDS_SCL_PERIOD_NS + 4 * CDS_CLK_NS - 1) / (4 * CDS_CLK_NS);
    localparam int         CDS_MAX_CH        = 4;
    localparam int         CDS_SYNC_W        = 4;
    localparam int         CDS_PIN_SCL       = 0;
    localparam int         CDS_PIN_SDA       = 1;
    localparam int         CDS_PIN_STRAP_LO  = 2;
    localparam int         CDS_PIN_STRAP_HI  = 3;
    localparam logic [3:0] CDS_SYNC_RST      = 4'h3;
    localparam logic [4:0] CDS_ADDR_LOW5     = 5'h10;
    localparam logic [7:0] CDS_CH_BASE       = 8'hF8;
    localparam logic [7:0] CDS_CH_RST        = 8'h00;
    localparam logic [7:0] CDS_NUM_CH_FULL   = 8'h04;
    localparam logic [7:0] CDS_NUM_CH_HALF   = 8'h02;
    localparam logic [3:0] CDS_BIT_LAST      = 4'h7;
    localparam logic [3:0] CDS_BIT_ACK       = 4'h8;
    localparam logic       CDS_DIR_READ      = 1'h1;
    localparam int         CDS_SIGN_BIT      = 7;
    localparam int         CDS_MAG_MSB       = 6;
    localparam logic [1:0] CDS_IDX_ADDR      = 2'h0;
    localparam logic [1:0] CDS_IDX_MEM       = 2'h1;
    localparam logic [1:0] CDS_IDX_DATA      = 2'h2;

    typedef logic [7:0] cds_byte_t;

    typedef enum logic [2:0] {
        CDS_S_IDLE    = 3'h0,
        CDS_S_RX      = 3'h1,
        CDS_S_RX_ACK  = 3'h2,
        CDS_S_TX      = 3'h3,
        CDS_S_TX_ACK  = 3'h4,
        CDS_S_TX_NEXT = 3'h5,
        CDS_S_IGNORE  = 3'h6
    } cds_slv_state_e;

    typedef enum logic [1:0] {
        CDS_M_IDLE  = 2'h0,
        CDS_M_START = 2'h1,
        CDS_M_BIT   = 2'h2,
        CDS_M_STOP  = 2'h3
    } cds_mst_state_e;
endpackage : cds_pkg

// ### hw/cds_slave.sv
`timescale 1ns/1ns
module cds_slave #(
    parameter bit FOUR_CH = 1'b1
) (
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    cds_if.slave                   bus,
    input  wire logic              addr_strap_low,
    input  wire logic              addr_strap_high,
    output cds_pkg::cds_byte_t     current_channel_0,
    output cds_pkg::cds_byte_t     current_channel_1,
    output cds_pkg::cds_byte_t     current_channel_2,
    output cds_pkg::cds_byte_t     current_channel_3,
    output logic [3:0]             current_on
);
    import cds_pkg::*;

    localparam logic [7:0] NUM_CH = FOUR_CH ? CDS_NUM_CH_FULL : CDS_NUM_CH_HALF;

    logic [2:0][CDS_SYNC_W-1:0] sync_reg;
    logic [2:0][CDS_SYNC_W-1:0] sync_next;
    logic [CDS_SYNC_W-1:0]      filt_reg;
    logic [CDS_SYNC_W-1:0]      filt_next;
    logic [CDS_SYNC_W-1:0]      prev_reg;
    logic [CDS_SYNC_W-1:0]      prev_next;
    logic [CDS_SYNC_W-1:0]      pin_in;

    cds_slv_state_e             st_reg;
    cds_slv_state_e             st_next;
    logic [3:0]                 cnt_reg;
    logic [3:0]                 cnt_next;
    cds_byte_t                  sh_reg;
    cds_byte_t                  sh_next;
    cds_byte_t                  ptr_reg;
    cds_byte_t                  ptr_next;
    logic [1:0]                 idx_reg;
    logic [1:0]                 idx_next;
    logic                       rw_reg;
    logic                       rw_next;
    logic                       oe_n_reg;
    logic                       oe_n_next;
    cds_byte_t                  ch_reg [CDS_MAX_CH];
    cds_byte_t                  ch_next [CDS_MAX_CH];

    logic                       scl_rise;
    logic                       scl_fall;
    logic                       start_cond;
    logic                       stop_cond;
    logic                       sda_f;
    logic [6:0]                 own_addr;
    cds_byte_t                  offs;
    logic                       ch_hit;
    cds_byte_t                  rd_byte;

    assign pin_in = {addr_strap_high, addr_strap_low, bus.sda, bus.scl};

    // Three-stage sampling, level accepted when stages two and three agree
    always_comb
    begin
        sync_next[0] = pin_in;
        sync_next[1] = sync_reg[0];
        sync_next[2] = sync_reg[1];
        prev_next    = filt_reg;
        filt_next    = ((sync_reg[1] ^ sync_reg[2]) & filt_reg)
                     | (~(sync_reg[1] ^ sync_reg[2]) & sync_reg[2]);
    end
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync_reg <= {3{CDS_SYNC_RST}};
            filt_reg <= CDS_SYNC_RST;
            prev_reg <= CDS_SYNC_RST;
        end
        else
        begin
            sync_reg <= sync_next;
            filt_reg <= filt_next;
            prev_reg <= prev_next;
        end
    end
    assign sda_f      = filt_reg[CDS_PIN_SDA];
    assign scl_rise   = filt_reg[CDS_PIN_SCL] & ~prev_reg[CDS_PIN_SCL];
    assign scl_fall   = ~filt_reg[CDS_PIN_SCL] & prev_reg[CDS_PIN_SCL];
    assign start_cond = filt_reg[CDS_PIN_SCL] & prev_reg[CDS_PIN_SCL]
                      & prev_reg[CDS_PIN_SDA] & ~sda_f;
    assign stop_cond  = filt_reg[CDS_PIN_SCL] & prev_reg[CDS_PIN_SCL]
                      & ~prev_reg[CDS_PIN_SDA] & sda_f;
    assign own_addr = {filt_reg[CDS_PIN_STRAP_HI], filt_reg[CDS_PIN_STRAP_LO],
                       CDS_ADDR_LOW5};
    assign offs     = ptr_reg - CDS_CH_BASE;
    assign ch_hit   = offs < NUM_CH;
    assign rd_byte  = ch_hit ? ch_reg[offs[1:0]] : CDS_CH_RST;
    always_comb
    begin
        st_next   = st_reg;
        cnt_next  = cnt_reg;
        sh_next   = sh_reg;
        ptr_next  = ptr_reg;
        idx_next  = idx_reg;
        rw_next   = rw_reg;
        oe_n_next = oe_n_reg;
        ch_next   = ch_reg;
        if (start_cond)
        begin
            st_next   = CDS_S_RX;
            cnt_next  = '0;
            idx_next  = CDS_IDX_ADDR;
            oe_n_next = 1'h1;
        end
        else if (stop_cond)
        begin
            st_next   = CDS_S_IDLE;
            oe_n_next = 1'h1;
        end
        else
        begin
            unique case (st_reg)
                CDS_S_IDLE, CDS_S_IGNORE: ;
                CDS_S_RX:
                begin
                    if (scl_rise && cnt_reg < CDS_BIT_ACK)
                    begin
                        sh_next  = {sh_reg[6:0], sda_f};
                        cnt_next = cnt_reg + 4'h1;
                    end
                    else if (scl_fall && cnt_reg == CDS_BIT_ACK)
                    begin
                        if (idx_reg == CDS_IDX_ADDR && sh_reg[7:1] != own_addr)
                            st_next = CDS_S_IGNORE;
                        else
                        begin
                            oe_n_next = 1'h0;
                            st_next   = CDS_S_RX_ACK;
                            if (idx_reg == CDS_IDX_ADDR)
                                rw_next = sh_reg[0];
                            if (idx_reg == CDS_IDX_MEM)
                                ptr_next = sh_reg;
                        end
                    end
                end
                CDS_S_RX_ACK:
                begin
                    if (scl_fall)
                    begin
                        oe_n_next = 1'h1;
                        cnt_next  = '0;
                        if (idx_reg == CDS_IDX_ADDR && rw_reg == CDS_DIR_READ)
                        begin
                            sh_next   = rd_byte;
                            oe_n_next = rd_byte[7];
                            st_next   = CDS_S_TX;
                        end
                        else
                        begin
                            st_next = CDS_S_RX;
                            if (idx_reg == CDS_IDX_DATA)
                            begin
                                if (ch_hit)
                                    ch_next[offs[1:0]] = sh_reg;
                                ptr_next = ptr_reg + 8'h01;
                            end
                            else
                                idx_next = idx_reg + 2'h1;
                        end
                    end
                end
                CDS_S_TX:
                begin
                    if (scl_fall)
                    begin
                        if (cnt_reg == CDS_BIT_LAST)
                        begin
                            oe_n_next = 1'h1;
                            cnt_next  = '0;
                            st_next   = CDS_S_TX_ACK;
                        end
                        else
                        begin
                            sh_next   = {sh_reg[6:0], 1'h0};
                            oe_n_next = sh_reg[6];
                            cnt_next  = cnt_reg + 4'h1;
                        end
                    end
                end
                CDS_S_TX_ACK:
                begin
                    if (scl_rise)
                    begin
                        if (sda_f)
                            st_next = CDS_S_IGNORE;
                        else
                        begin
                            st_next  = CDS_S_TX_NEXT;
                            ptr_next = ptr_reg + 8'h01;
                        end
                    end
                end
                CDS_S_TX_NEXT:
                begin
                    if (scl_fall)
                    begin
                        sh_next   = rd_byte;
                        oe_n_next = rd_byte[7];
                        st_next   = CDS_S_TX;
                    end
                end
                default:
                begin
                    st_next   = CDS_S_IDLE;
                    oe_n_next = 1'h1;
                end
            endcase
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_reg   <= CDS_S_IDLE;
            cnt_reg  <= '0;
            sh_reg   <= CDS_CH_RST;
            ptr_reg  <= CDS_CH_RST;
            idx_reg  <= CDS_IDX_ADDR;
            rw_reg   <= 1'h0;
            oe_n_reg <= 1'h1;
            for (int i = 0; i < CDS_MAX_CH; i++)
                ch_reg[i] <= CDS_CH_RST;
        end
        else
        begin
            st_reg   <= st_next;
            cnt_reg  <= cnt_next;
            sh_reg   <= sh_next;
            ptr_reg  <= ptr_next;
            idx_reg  <= idx_next;
            rw_reg   <= rw_next;
            oe_n_reg <= oe_n_next;
            ch_reg   <= ch_next;
        end
    end

    assign bus.s_sda_o    = 1'h0;
    assign bus.s_sda_oe_n = oe_n_reg;
    assign current_channel_0 = ch_reg[0];
    assign current_channel_1 = ch_reg[1];
    assign current_channel_2 = ch_reg[2];
    assign current_channel_3 = ch_reg[3];
    // Zero magnitude gives no current whatever the sign
    for (genvar g = 0; g < CDS_MAX_CH; g++)
    begin : g_on
        assign current_on[g] = |ch_reg[g][CDS_MAG_MSB:0];
    end
endmodule : cds_slave

// ### tb/cds_chk_sva.sv
`timescale 1ns/1ns
module cds_chk (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic scl,
    input wire logic sda,
    input wire logic s_sda_oe_n
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence start_s;
        scl && $fell(sda);
    endsequence
    sequence stop_s;
        scl && $rose(sda);
    endsequence
    a_slave_edge_lag: assert property ($changed(s_sda_oe_n) |->
        !scl && !$past(scl, 2) && $past(scl, 8)) else $error("slave sda moved off scl low");
    a_ack_held: assert property ($fell(s_sda_oe_n) |=> (!s_sda_oe_n)[*8])
        else $error("slave drive too short");
    a_sda_release: assert property ($fell(s_sda_oe_n) |-> ##[1:400] $rose(s_sda_oe_n))
        else $error("slave never released sda");
    a_setup_first: assert property ($fell(s_sda_oe_n) |-> ##[4:8] $rose(scl))
        else $error("slave bit not set before scl rise");
    a_scl_low: assert property ($fell(scl) |=> (!scl)[*8])
        else $error("scl low phase short");
    a_scl_high: assert property ($rose(scl) |=> scl[*8])
        else $error("scl high phase short");
    a_start_form: assert property (start_s |=> scl[*4] ##[1:20] $fell(scl))
        else $error("start not followed by clocking");
    a_stop_idle: assert property (stop_s |=> (scl && sda && s_sda_oe_n)[*4])
        else $error("bus not idle after stop");
endmodule : cds_chk

// ### tb/tb.sv
`timescale 1ns/1ns
module tb;
    import cds_pkg::*;
    logic       clk_sys;
    logic       rst_n;
    logic       cmd_valid;
    logic       cmd_ready;
    logic       cmd_read;
    logic [6:0] cmd_dev_addr;
    cds_byte_t  cmd_mem_addr;
    cds_byte_t  cmd_wdata;
    logic       rsp_valid;
    cds_byte_t  rsp_rdata;
    logic       rsp_nack;
    logic [1:0] strap;
    cds_byte_t  chan [4];
    logic [3:0] current_on;
    int         err_total;
    int         checked;
    int         cycles;
    cds_if      bus ();
    cds_master cds_master_inst (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus.master),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read),
        .cmd_dev_addr(cmd_dev_addr), .cmd_mem_addr(cmd_mem_addr), .cmd_wdata(cmd_wdata),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_nack(rsp_nack));
    cds_slave cds_slave_inst (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus.slave),
        .addr_strap_low(strap[0]), .addr_strap_high(strap[1]), .current_channel_0(chan[0]),
        .current_channel_1(chan[1]), .current_channel_2(chan[2]),
        .current_channel_3(chan[3]), .current_on(current_on));
    cds_chk cds_chk_inst (.clk_sys(clk_sys), .rst_n(rst_n), .scl(bus.scl), .sda(bus.sda),
        .s_sda_oe_n(bus.s_sda_oe_n));
    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    task test_done;
        if (err_total == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done
    task chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: %h expected %h", $time, got, exp);
        end
    endtask : chk
    task xfer(input logic rd, input logic [6:0] dev, input cds_byte_t mem, input cds_byte_t wd);
        int n;
        n = 0;
        @(posedge clk_sys);
        cmd_valid <= 1'b1;
        cmd_read <= rd;
        cmd_dev_addr <= dev;
        cmd_mem_addr <= mem;
        cmd_wdata <= wd;
        @(posedge clk_sys);
        cmd_valid <= 1'b0;
        @(negedge clk_sys);
        chk({7'h00, cmd_ready}, 8'h00);
        while (rsp_valid !== 1'b1 && n < 2000)
        begin
            @(negedge clk_sys);
            n++;
        end
        chk({7'h00, rsp_valid}, 8'h01);
        chk({7'h00, cmd_ready}, 8'h01);
    endtask : xfer
    task t_straps;
        cds_byte_t d [4];
        d = '{8'h80, 8'h2A, 8'hD5, 8'h7F};
        for (int k = 0; k < 4; k++)
        begin
            @(posedge clk_sys);
            strap <= 2'(k);
            repeat (8) @(posedge clk_sys);
            xfer(1'b0, {2'(k), 5'h10}, CDS_CH_BASE + 8'(k), d[k]);
            chk({7'h00, rsp_nack}, 8'h00);
            chk(chan[k], d[k]);
            chk({7'h00, current_on[k]}, {7'h00, |d[k][6:0]});
        end
    endtask : t_straps
    task t_read;
        xfer(1'b0, 7'h70, 8'hF8, 8'hAA);
        chk(chan[0], 8'hAA);
        xfer(1'b1, 7'h70, 8'h00, 8'h00);
        // Pointer stepped past F8h on the write, so channel 1 comes back
        chk(rsp_rdata, 8'h2A);
        chk({7'h00, rsp_nack}, 8'h00);
    endtask : t_read
    task t_wrong;
        xfer(1'b0, 7'h10, 8'hF9, 8'h55);
        chk({7'h00, rsp_nack}, 8'h01);
        chk(chan[1], 8'h2A);
        xfer(1'b0, 7'h70, 8'hF9, 8'h55);
        chk(chan[1], 8'h55);
        chk({7'h00, rsp_nack}, 8'h00);
    endtask : t_wrong
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            err_total++;
            test_done();
        end
    end
    initial
    begin
        {rst_n, cmd_valid, cmd_read, strap, err_total, checked, cycles} = '0;
        {cmd_dev_addr, cmd_mem_addr, cmd_wdata} = '0;
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(negedge clk_sys);
        for (int k = 0; k < 4; k++) chk(chan[k], 8'h00);
        t_straps();
        t_read();
        t_wrong();
        test_done();
    end
endmodule : tb
